/* File: design/efbi_pkg.sv */
/*
 Package for the external flash bus interface: widths, timing counts and
 data constants shared by the flash end and the master end.
 Assumes a single 20 MHz clock and an active-low asynchronous reset.
*/
// Functional notes
// R1: Flash latches address on every write cycle; the code latches only while flash reset and byte mode are high.
// R2: Master drives data for command and writes.
// R3: Flash drives data to reader on reads.
// R4: Flash active only while chip enable low.
// R5: Flash reset low blocks writes, holds reset.
// R6: Output drivers enabled only during output enable.
// R7: Write strobe rising edge captures address, data.
// R8: Controller never drives write protect.
// R9: Keep write protect high for boot block.
// R10: Ready/busy reports write or erase done.
// R11: Byte mode held high, word access only.
// R12: Address up to 21 bits, size-dependent.
// R13: External master waits for controller release.
// R14: Status line low keeps controller off bus.
// R15: Never read and write strobes together.
package efbi_pkg;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   // Unused top address bits per density: 16M, 8M, 4M
   localparam int UNUSED_16M = 1;
   localparam int UNUSED_8M = 2;
   localparam int UNUSED_4M = 3;
   // Flash memory words modelled (kept small)
   localparam int MEM_WORDS = 256;
   // Program busy time in ns and derived cycles
   localparam int CLK_NS = 50;
   localparam int PROG_NS = 500;
   localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
   // Master strobe width base in cycles; the strobe lasts this plus 4 cycles
   localparam int STROBE_CYC = 2;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [15:0] ERASED = 16'hffff;
endpackage

/* File: design/efbi_if.sv */
/*
 Interface joining flash end and master end of the parallel flash bus.
 Carries data on two separate wires, dq_m and dq_f, each with its own enable; nothing merges them.
*/
`timescale 1ns/1ps
interface efbi_if;
   logic [20:0] addr;
   logic [15:0] dq_m;
   logic dq_m_oe;
   logic [15:0] dq_f;
   logic dq_f_oe;
   logic chip_en_n;
   logic out_en_n;
   logic write_n;
   logic flash_reset_n;
   logic write_protect_n;
   logic byte_mode_n;
   logic flash_ready_busy;
   logic fpga_status_n;
   modport flash (input addr, dq_m, dq_m_oe, chip_en_n, out_en_n, write_n,
      flash_reset_n, write_protect_n, byte_mode_n, fpga_status_n,
      output dq_f, dq_f_oe, flash_ready_busy);
   modport master (output addr, dq_m, dq_m_oe, chip_en_n, out_en_n, write_n,
      flash_reset_n, write_protect_n, byte_mode_n,
      input dq_f, dq_f_oe, flash_ready_busy, fpga_status_n);
endinterface

/* File: design/efbi_flash.sv */
/*
 Flash end: small word array behind the asynchronous strobe bus.
 Assumes the bus pins arrive from outside and are synchronised here.
*/
`timescale 1ns/1ps
module efbi_flash #(
   parameter int UNUSED_TOP = efbi_pkg::UNUSED_16M,
   parameter int WORDS = efbi_pkg::MEM_WORDS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus
   efbi_if.flash bus, // R8
   // Status
   output logic standby,
   output logic write_refused
);
   if (UNUSED_TOP < 1 || UNUSED_TOP > 3 || WORDS < 2) begin : g_bad_param
      $error("efbi_flash: bad parameters");
   end
   localparam int AW = efbi_pkg::ADDR_W;
   logic [15:0] mem [WORDS];
   logic [AW-1:0] a_s1, a_s2, addr_hold;
   logic [15:0] d_s1, d_s2, data_hold;
   logic wr_pend;
   logic [4:0] c_s1, c_s2;
   logic we_prev;
   logic [7:0] busy_cnt;
   logic ce, oe, we, rp;
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         a_s1 <= '0;
         a_s2 <= '0;
         d_s1 <= efbi_pkg::DATA_RST;
         d_s2 <= efbi_pkg::DATA_RST;
         c_s1 <= 5'h0f;
         c_s2 <= 5'h0f;
      end else begin
         a_s1 <= bus.addr;
         a_s2 <= a_s1;
         d_s1 <= bus.dq_m;
         d_s2 <= d_s1;
         c_s1 <= {bus.byte_mode_n, bus.flash_reset_n, bus.write_n, bus.out_en_n,
            bus.chip_en_n};
         c_s2 <= c_s1;
      end
   end
   assign ce = !c_s2[0]; // R4
   assign oe = ce && !c_s2[1];
   assign we = ce && !c_s2[2];
   assign rp = c_s2[3];
   // ------------------------------------------------------------
   // Write capture on strobe rise
   // ------------------------------------------------------------
   function automatic int word_index(input logic [AW-1:0] a);
      logic [AW-1:0] m;
      m = a & ({AW{1'b1}} >> UNUSED_TOP); // R12
      return int'(m) % WORDS;
   endfunction
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         we_prev <= 1'b0;
         addr_hold <= '0;
         data_hold <= efbi_pkg::DATA_RST;
         wr_pend <= 1'b0;
         busy_cnt <= '0;
         write_refused <= 1'b0;
      end else begin
         we_prev <= we;
         write_refused <= 1'b0;
         wr_pend <= 1'b0;
         if (busy_cnt != 8'h00)
            busy_cnt <= busy_cnt - 8'h01;
         if (we && !we_prev && !rp)
            write_refused <= 1'b1; // R5
         if (!we && we_prev && rp && c_s2[4]) begin // R11
            addr_hold <= a_s2; // R1 R7
            data_hold <= d_s2; // R7
            wr_pend <= 1'b1;
            busy_cnt <= 8'(efbi_pkg::PROG_CYC);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (wr_pend)
         mem[word_index(addr_hold)] <= data_hold; // R1
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus.dq_f <= efbi_pkg::DATA_RST;
         bus.dq_f_oe <= 1'b0;
         bus.flash_ready_busy <= 1'b1;
         standby <= 1'b1;
      end else begin
         bus.dq_f <= mem[word_index(a_s2)]; // R3
         bus.dq_f_oe <= oe && rp && !we; // R6
         bus.flash_ready_busy <= (busy_cnt == 8'h00); // R10
         standby <= !ce; // R4
      end
   end
endmodule

/* File: design/efbi_master.sv */
/*
 Master end: external party driving single-word reads and writes.
 Assumes bus pins from the flash end cross into this clock domain.
*/
`timescale 1ns/1ps
module efbi_master (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus
   efbi_if.master bus,
   // User request
   input wire logic req,
   input wire logic req_write,
   input wire logic [20:0] req_addr,
   input wire logic [15:0] req_data,
   // User answer
   output logic done,
   output logic [15:0] rd_data
);
   typedef enum logic [2:0] {
      EFBI_IDLE = 3'b000, EFBI_SETUP = 3'b001, EFBI_STROBE = 3'b011,
      EFBI_HOLD = 3'b010, EFBI_WAIT = 3'b110
   } efbi_state_t;
   efbi_state_t state;
   logic [3:0] cnt;
   logic wr;
   logic [15:0] dq_s1, dq_s2;
   logic st_s1, st_s2;
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_s1 <= efbi_pkg::DATA_RST;
         dq_s2 <= efbi_pkg::DATA_RST;
         st_s1 <= 1'b1;
         st_s2 <= 1'b1;
      end else begin
         dq_s1 <= bus.dq_f;
         dq_s2 <= dq_s1;
         st_s1 <= bus.fpga_status_n;
         st_s2 <= st_s1;
      end
   end
   // ------------------------------------------------------------
   // Cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= EFBI_IDLE;
         cnt <= '0;
         wr <= 1'b0;
         done <= 1'b0;
         rd_data <= efbi_pkg::DATA_RST;
         bus.addr <= '0;
         bus.dq_m <= efbi_pkg::DATA_RST;
         bus.dq_m_oe <= 1'b0;
         bus.chip_en_n <= 1'b1;
         bus.out_en_n <= 1'b1;
         bus.write_n <= 1'b1;
         bus.flash_reset_n <= 1'b0;
         bus.write_protect_n <= 1'b1; // R9
         bus.byte_mode_n <= 1'b1; // R11
      end else begin
         done <= 1'b0;
         bus.flash_reset_n <= 1'b1;
         case (state)
            EFBI_IDLE: begin
               if (req && !st_s2) begin // R13 R14
                  wr <= req_write;
                  bus.addr <= req_addr;
                  bus.dq_m <= req_data;
                  bus.dq_m_oe <= req_write; // R2 R15
                  bus.chip_en_n <= 1'b0;
                  state <= EFBI_SETUP;
               end
            end
            EFBI_SETUP: begin
               cnt <= 4'(efbi_pkg::STROBE_CYC + 3);
               if (wr)
                  bus.write_n <= 1'b0; // R7
               else
                  bus.out_en_n <= 1'b0; // R6 R15
               state <= EFBI_STROBE;
            end
            EFBI_STROBE: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  rd_data <= dq_s2; // R3
                  bus.write_n <= 1'b1; // R7
                  bus.out_en_n <= 1'b1;
                  state <= EFBI_HOLD;
               end
            end
            EFBI_HOLD: begin
               cnt <= 4'h3;
               bus.dq_m_oe <= 1'b0;
               bus.chip_en_n <= 1'b1;
               state <= EFBI_WAIT;
            end
            EFBI_WAIT: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  done <= 1'b1;
                  state <= EFBI_IDLE;
               end
            end
            default: state <= EFBI_IDLE;
         endcase
      end
   end
endmodule

/* File: sim/efbi_bus_sva.sv */
/*
 Checker for the flash bus between the master end and the flash end.
 Assumes the testbench instantiates it beside the joining interface.
*/
`timescale 1ns/1ps
module efbi_bus_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus signals
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_m,
   input wire logic dq_m_oe,
   input wire logic [15:0] dq_f,
   input wire logic dq_f_oe,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic flash_reset_n,
   input wire logic write_protect_n,
   input wire logic byte_mode_n,
   input wire logic flash_ready_busy,
   input wire logic fpga_status_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_no_read_write: assert property (!(!out_en_n && !write_n))
      else $error("read and write strobes low together");
   chk_read_released: assert property (!out_en_n |-> !dq_m_oe)
      else $error("master drives data during read");
   chk_write_drives: assert property (!write_n |-> dq_m_oe && !chip_en_n)
      else $error("write strobe without data or select");
   chk_drive_on: assert property ((!out_en_n && !chip_en_n && flash_reset_n)[*5] |-> dq_f_oe)
      else $error("flash not driving during read");
   chk_drive_off: assert property ((out_en_n || chip_en_n)[*5] |-> !dq_f_oe)
      else $error("flash drives without read select");
   chk_busy_start: assert property ($rose(write_n) && !chip_en_n && flash_reset_n && byte_mode_n
      |-> ##[2:6] !flash_ready_busy)
      else $error("write not captured");
   chk_busy_length: assert property ($fell(flash_ready_busy)
      |-> !flash_ready_busy[*8] ##[1:3] flash_ready_busy)
      else $error("busy span wrong");
   chk_wp_static: assert property (write_protect_n && $stable(write_protect_n))
      else $error("write protect moved");
   chk_word_mode: assert property (byte_mode_n)
      else $error("byte mode selected");
   chk_status_off: assert property (fpga_status_n[*4] |-> chip_en_n)
      else $error("master on bus while held off");
   cov_read: cover property (!out_en_n ##1 out_en_n);
   cov_write: cover property ($rose(write_n) && !chip_en_n);
   cov_busy: cover property ($rose(flash_ready_busy));
endmodule

/* File: sim/testbench.sv */
/*
 Testbench: master end and flash end joined on one bus, plus a second
 flash end driven directly. Assumes package and interface compile first.
*/
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [20:0] req_addr = 21'h000000;
   logic [15:0] req_data = 16'h0000;
   logic done;
   logic [15:0] rd_data;
   logic standby;
   logic standby_b;
   logic refused;
   logic refused_main;
   logic [1:0] hit;
   int n_fail = 0;
   int comparisons = 0;
   int k;
   // Word 5 written through an alias: top bit unused, 256 words
   logic [20:0] wa [4] = '{21'h000000, 21'h0000ff, 21'h100005, 21'h000000};
   logic [15:0] wd [4] = '{16'h1111, 16'hfffe, 16'h5a5a, 16'h0f0f};
   logic [20:0] ra [3] = '{21'h000000, 21'h0000ff, 21'h000005};
   efbi_if bus();
   efbi_if bus_b();
   efbi_master i_efbi_master (.clk(clk), .rst_b(rst_b), .bus(bus.master), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .done(done),
      .rd_data(rd_data));
   efbi_flash i_efbi_flash (.clk(clk), .rst_b(rst_b), .bus(bus.flash), .standby(standby),
      .write_refused(refused_main));
   efbi_flash i_efbi_flash_b (.clk(clk), .rst_b(rst_b), .bus(bus_b.flash),
      .standby(standby_b), .write_refused(refused));
   efbi_bus_sva i_efbi_bus_sva (.clk(clk), .rst_b(rst_b), .addr(bus.addr), .dq_m(bus.dq_m),
      .dq_m_oe(bus.dq_m_oe), .dq_f(bus.dq_f), .dq_f_oe(bus.dq_f_oe),
      .chip_en_n(bus.chip_en_n), .out_en_n(bus.out_en_n), .write_n(bus.write_n),
      .flash_reset_n(bus.flash_reset_n), .write_protect_n(bus.write_protect_n),
      .byte_mode_n(bus.byte_mode_n), .flash_ready_busy(bus.flash_ready_busy),
      .fpga_status_n(bus.fpga_status_n));
   always #25 clk = ~clk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One user transfer; live low means it must be ignored
   task automatic run(input logic wr, input logic [20:0] a, input logic [15:0] d, input logic live);
      @(posedge clk);
      req <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_data <= d;
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
         if (k == 6) check("standby", {15'h0, standby}, {15'h0, ~live});
      end
      check("done cycle", 16'(k), live ? 16'h000c : 16'h0014);
      @(posedge clk);
      #1;
      check("done pulse", {15'h0, done}, 16'h0000);
      repeat (efbi_pkg::PROG_CYC + 6) @(posedge clk);
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      bus.fpga_status_n = 1'b0;
      bus_b.addr = 21'h000003;
      bus_b.dq_m = 16'hc3c3;
      bus_b.dq_m_oe = 1'b1;
      bus_b.chip_en_n = 1'b0;
      bus_b.out_en_n = 1'b1;
      bus_b.write_n = 1'b1;
      bus_b.flash_reset_n = 1'b0;
      bus_b.write_protect_n = 1'b1;
      bus_b.byte_mode_n = 1'b1;
      bus_b.fpga_status_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("standby idle", {15'h0, standby}, 16'h0001);
      for (int i = 0; i < 4; i++) run(1'b1, wa[i], wd[i], 1'b1);
      for (int i = 0; i < 3; i++) begin
         run(1'b0, ra[i], 16'h0000, 1'b1);
         check("read data", rd_data, i == 0 ? wd[3] : wd[i]);
      end
      $display("write and read test done");
      bus.fpga_status_n <= 1'b1;
      repeat (4) @(posedge clk);
      run(1'b1, 21'h000000, 16'hdead, 1'b0);
      bus.fpga_status_n <= 1'b0;
      repeat (4) @(posedge clk);
      run(1'b0, 21'h000000, 16'h0000, 1'b1);
      check("read after hold off", rd_data, 16'h0f0f);
      $display("hold off test done");
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         bus_b.flash_reset_n <= p[0];
         repeat (4) @(posedge clk);
         hit = 2'b00;
         for (int i = 0; i < 14; i++) begin
            @(posedge clk);
            bus_b.write_n <= (i >= 4);
            #1;
            hit = hit | {refused, ~bus_b.flash_ready_busy};
         end
         check("refused and busy", {14'h0, hit}, p ? 16'h0001 : 16'h0002);
      end
      check("standby b", {15'h0, standby_b}, 16'h0000);
      $display("flash reset test done");
      summarize();
   end
   initial begin
      #200us;
      n_fail++;
      $display("[FAIL] run end expected before limit seen timeout");
      summarize();
   end
endmodule
